// [rtl/xosc_map.vh]
// Constants of the crystal oscillator stabilization counter block.
// Assumes an APB slave on pclk; register index times four is the byte address.
//
// What this block does
// (RL1) Status byte clears on reset, STOP instruction, or oscillator halt bit written 1.
// (RL2) Counter starts when crystal mode is selected and the halt bit is 0.
// (RL3) Counter restarts from zero when STOP mode is exited.
// (RL4) Status bits 7..0 set at 2^8,9,10,11,13,15,17,18 cycles and stay set.
// (RL5) Counter stops at the selected wait length; status never passes it.
// (RL6) Wait select codes 0..7 choose 2^8,9,10,11,13,15,17,18 cycles.
// (RL7) Wait select resets to 07h; bits 7..3 read zero.
// (RL8) With crystal as CPU clock, execution is held after STOP exit until done.
// (RL9) On internal oscillator clock, software polls status after STOP exit.
// (RL10) Software programs wait select before STOP when crystal runs the CPU.
// (RL11) Software never selects a wait of 20 us or less.
// (RL12) Software changes wait select only after the count has completed.
// (RL13) Software selects a wait at least as long as the threshold it checks.
// (RL14) Only real oscillator cycles are counted; start-up delay is excluded.
// (RL15) Status byte is read-only, resets to 00h.
// (RL16) Software writes wait select with whole-byte accesses only.
// (RL17) Halt bit 0 runs, 1 stops the crystal oscillator in crystal mode.
// (RL18) Mode bits 0,1 crystal; 1,1 external clock; select bit 0 input port.
// (RL19) Up-counter on crystal cycles; status from threshold compares, saturating.
`ifndef XOSC_MAP_VH
`define XOSC_MAP_VH

`define XOSC_IDX_MODE 20'hfffa0
`define XOSC_IDX_RUN 20'hfffa1
`define XOSC_IDX_STATUS 20'hfffa2
`define XOSC_IDX_SELECT 20'hfffa3
`define XOSC_IDX_IRQ_ST 20'hfffb0
`define XOSC_IDX_IRQ_EN 20'hfffb1
`define XOSC_IDX_IRQ_CLR 20'hfffb2

`define XOSC_MODE_EXT_BIT 7
`define XOSC_MODE_SEL_BIT 6
`define XOSC_RUN_HALT_BIT 7
`define XOSC_IRQ_DONE_BIT 0
`define XOSC_IRQ_START_BIT 1

`define XOSC_MODE_RST 2'h0
`define XOSC_HALT_RST 1'h1
`define XOSC_SEL_RST 3'h7
`define XOSC_STATUS_RST 8'h00

`define XOSC_EXP_0 5'h08
`define XOSC_EXP_1 5'h09
`define XOSC_EXP_2 5'h0a
`define XOSC_EXP_3 5'h0b
`define XOSC_EXP_4 5'h0d
`define XOSC_EXP_5 5'h0f
`define XOSC_EXP_6 5'h11
`define XOSC_EXP_7 5'h12

`endif

// [rtl/xosc_cnt.v]
// Saturating up-counter of crystal cycles.
// Assumes tick is a one-cycle pulse per crystal cycle, already in the pclk domain.
`timescale 1ns/10ps
`default_nettype none
module xosc_cnt #(
    parameter CNT_W = 19
) (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // Control.
    input wire clear,
    input wire tick,
    input wire done,
    // Count.
    output reg [CNT_W-1:0] count
);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= {CNT_W{1'b0}};
        end else if (clear) begin
            count <= {CNT_W{1'b0}}; // RL1
        end else if (tick && !done) begin
            count <= count + {{(CNT_W-1){1'b0}}, 1'b1}; // RL5
        end
    end

endmodule // xosc_cnt
`default_nettype wire

// [rtl/xosc_thermo.v]
// Thermometer decode of the cycle count and the reached flag of the selected wait.
// Assumes count saturates at the selected wait, so the status never passes it.
`timescale 1ns/10ps
`default_nettype none
`include "xosc_map.vh"
module xosc_thermo #(
    parameter CNT_W = 19
) (
    // Inputs.
    input wire [CNT_W-1:0] count,
    input wire [2:0] sel,
    // Outputs.
    output reg [7:0] status,
    output wire done
);

    function [4:0] wait_exp;
        input [2:0] code;
        begin
            case (code)
                3'h0: wait_exp = `XOSC_EXP_0;
                3'h1: wait_exp = `XOSC_EXP_1;
                3'h2: wait_exp = `XOSC_EXP_2;
                3'h3: wait_exp = `XOSC_EXP_3;
                3'h4: wait_exp = `XOSC_EXP_4;
                3'h5: wait_exp = `XOSC_EXP_5;
                3'h6: wait_exp = `XOSC_EXP_6;
                default: wait_exp = `XOSC_EXP_7;
            endcase
        end
    endfunction

    function reached;
        input [CNT_W-1:0] cnt;
        input [2:0] code;
        begin
            reached = (cnt >> wait_exp(code)) != {CNT_W{1'b0}};
        end
    endfunction

    integer i;

    always @* begin
        status = `XOSC_STATUS_RST;
        for (i = 0; i < 8; i = i + 1) begin
            status[7-i] = reached(count, i[2:0]); // RL4
        end
    end

    assign done = reached(count, sel); // RL6

endmodule // xosc_thermo
`default_nettype wire

// [rtl/xosc_stab.v]
// Crystal oscillator stabilization counter with its APB register file.
// Assumes the crystal clock arrives as a pin slower than pclk / 2 and that
// the CPU reports STOP entry and STOP release as one-cycle pulses on pclk.
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "xosc_map.vh"
module xosc_stab #(
    parameter CNT_W = 19,
    parameter ADDR_W = 22
) (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Crystal pin and CPU status.
    input wire xtal_clk_in,
    input wire stop_exec,
    input wire stop_release,
    input wire cpu_on_xtal,
    // Oscillator and pin control.
    output reg xtal_osc_en,
    output reg ext_clk_en,
    output reg pins_as_port,
    output reg cpu_hold,
    // Interrupt.
    output reg irq
);

    ////////////////////////////////////////////////////////////////////////
    // Register state.

    reg ext_clock_mode_bit;
    reg osc_pin_select_bit;
    reg hs_osc_halt;
    reg [2:0] stab_wait_select;
    reg [1:0] irq_status;
    reg [1:0] irq_enable;
    reg in_stop;
    reg xtal_sync1;
    reg xtal_sync2;
    reg xtal_sync3;
    reg done_q;
    reg osc_run_q;

    wire [CNT_W-1:0] count;
    wire [7:0] stab_status_byte;
    wire done;
    wire [19:0] reg_idx;
    wire access;
    wire wr;
    wire xtal_mode;
    wire ext_mode;
    wire osc_run;
    wire tick;
    wire halt_set_wr;
    wire cnt_clear;
    wire [1:0] irq_events;
    wire [1:0] irq_clear;

    reg hit;
    reg [31:0] rd_value;
    reg next_cpu_hold;
    wire [1:0] next_irq_status;

    // Reset pattern of the two mode bits, split into its fields below.
    localparam [1:0] MODE_RST = `XOSC_MODE_RST;

    // Write strobe of one register index, shared by the side-effect decodes.
    function wr_to;
        input strobe;
        input [19:0] idx;
        input [19:0] target;
        begin
            wr_to = strobe && (idx == target);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // APB decode.

    assign reg_idx = paddr[21:2];
    assign access = psel && penable;
    assign wr = access && pwrite && pstrb[0] && hit;
    assign pready = 1'b1;
    assign pslverr = access && !hit;

    always @* begin
        hit = 1'b1;
        rd_value = 32'h0000_0000;
        case (reg_idx)
            `XOSC_IDX_MODE: begin
                rd_value[`XOSC_MODE_EXT_BIT] = ext_clock_mode_bit;
                rd_value[`XOSC_MODE_SEL_BIT] = osc_pin_select_bit;
            end
            `XOSC_IDX_RUN: begin
                rd_value[`XOSC_RUN_HALT_BIT] = hs_osc_halt;
            end
            `XOSC_IDX_STATUS: begin
                rd_value[7:0] = stab_status_byte; // RL15
            end
            `XOSC_IDX_SELECT: begin
                rd_value[2:0] = stab_wait_select; // RL7
            end
            `XOSC_IDX_IRQ_ST: begin
                rd_value[1:0] = irq_status;
            end
            `XOSC_IDX_IRQ_EN: begin
                rd_value[1:0] = irq_enable;
            end
            `XOSC_IDX_IRQ_CLR: begin
                rd_value = 32'h0000_0000;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Read data is captured in the setup phase so it is stable for the
    // whole access phase with a zero-wait answer.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= rd_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers.

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_clock_mode_bit <= MODE_RST[1];
            osc_pin_select_bit <= MODE_RST[0];
            hs_osc_halt <= `XOSC_HALT_RST;
            stab_wait_select <= `XOSC_SEL_RST; // RL7
            irq_enable <= 2'h0;
        end else if (wr) begin
            case (reg_idx)
                `XOSC_IDX_MODE: begin
                    ext_clock_mode_bit <= pwdata[`XOSC_MODE_EXT_BIT];
                    osc_pin_select_bit <= pwdata[`XOSC_MODE_SEL_BIT];
                end
                `XOSC_IDX_RUN: begin
                    hs_osc_halt <= pwdata[`XOSC_RUN_HALT_BIT]; // RL17
                end
                `XOSC_IDX_SELECT: begin
                    stab_wait_select <= pwdata[2:0]; // RL6
                end
                `XOSC_IDX_IRQ_EN: begin
                    irq_enable <= pwdata[1:0];
                end
                default: begin
                    irq_enable <= irq_enable;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator mode and pin control.

    assign xtal_mode = osc_pin_select_bit && !ext_clock_mode_bit; // RL18
    assign ext_mode = osc_pin_select_bit && ext_clock_mode_bit; // RL18
    assign osc_run = xtal_mode && !hs_osc_halt && !in_stop; // RL2

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_osc_en <= 1'b0;
            ext_clk_en <= 1'b0;
            pins_as_port <= 1'b1;
        end else begin
            xtal_osc_en <= osc_run; // RL17
            ext_clk_en <= ext_mode && !hs_osc_halt && !in_stop;
            pins_as_port <= !osc_pin_select_bit; // RL18
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Crystal cycle detection.

    // Only rising edges of the running crystal are counted, so any start-up
    // delay with no oscillation adds nothing to the wait.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_sync1 <= 1'b0;
            xtal_sync2 <= 1'b0;
            xtal_sync3 <= 1'b0;
        end else begin
            xtal_sync1 <= xtal_clk_in;
            xtal_sync2 <= xtal_sync1;
            xtal_sync3 <= xtal_sync2;
        end
    end

    assign tick = xtal_sync2 && !xtal_sync3 && osc_run; // RL14

    ////////////////////////////////////////////////////////////////////////
    // STOP mode tracking.

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_stop <= 1'b0;
        end else if (stop_exec) begin
            in_stop <= 1'b1;
        end else if (stop_release) begin
            in_stop <= 1'b0;
        end
    end

    assign halt_set_wr = wr_to(wr, reg_idx, `XOSC_IDX_RUN) && pwdata[`XOSC_RUN_HALT_BIT];
    assign cnt_clear = stop_exec || halt_set_wr || in_stop || stop_release; // RL1

    ////////////////////////////////////////////////////////////////////////
    // Counter and status decode.

    xosc_cnt #(
        .CNT_W(CNT_W)
    ) xosc_cnt_inst (
        .pclk(pclk),
        .presetn(presetn),
        .clear(cnt_clear), // RL3
        .tick(tick),
        .done(done), // RL5
        .count(count) // RL19
    );

    xosc_thermo #(
        .CNT_W(CNT_W)
    ) xosc_thermo_inst (
        .count(count),
        .sel(stab_wait_select),
        .status(stab_status_byte), // RL4
        .done(done)
    );

    ////////////////////////////////////////////////////////////////////////
    // CPU hold after STOP exit.

    // The hold clears on the cycle after the count reaches the selected wait.
    // A stopped oscillator never reaches it, so the hold is dropped then
    // rather than freezing the CPU for good.
    always @* begin
        next_cpu_hold = cpu_hold;
        if (stop_release && cpu_on_xtal) begin
            next_cpu_hold = 1'b1; // RL8
        end else if (done || !osc_run) begin
            next_cpu_hold = 1'b0; // RL8
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_hold <= 1'b0;
        end else begin
            cpu_hold <= next_cpu_hold; // RL8
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts.

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
            osc_run_q <= 1'b0;
        end else begin
            done_q <= done;
            osc_run_q <= osc_run;
        end
    end

    assign irq_events[`XOSC_IRQ_DONE_BIT] = done && !done_q;
    assign irq_events[`XOSC_IRQ_START_BIT] = osc_run && !osc_run_q;
    assign irq_clear = wr_to(wr, reg_idx, `XOSC_IDX_IRQ_CLR) ? pwdata[1:0] : 2'h0;

    // A new event in the clearing cycle keeps its bit set.
    assign next_irq_status = (irq_status & ~irq_clear) | irq_events;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 2'h0;
            irq <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq <= |(next_irq_status & irq_enable);
        end
    end

endmodule // xosc_stab
`default_nettype wire

// [test/xosc_stab_asserts.sv]
// Port assertions of the stabilization counter block.
// Assumes one pclk domain and the register map of xosc_map.vh.
`timescale 1ns/10ps
`default_nettype none
`include "xosc_map.vh"
module xosc_chk #(
    parameter ADDR_W = 22
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    // Block pins.
    input wire logic stop_exec,
    input wire logic stop_release,
    input wire logic cpu_on_xtal,
    input wire logic xtal_osc_en,
    input wire logic ext_clk_en,
    input wire logic pins_as_port,
    input wire logic cpu_hold
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_acc = psel && penable && !pwrite;
    wire [ADDR_W-3:0] idx = paddr[ADDR_W-1:2];
    ////////////////////////////////////////
    sequence s_halt_wr;
        psel && penable && pwrite && pstrb[0] && idx == `XOSC_IDX_RUN &&
            pwdata[`XOSC_RUN_HALT_BIT];
    endsequence
    property p_halt;
        s_halt_wr |-> ##[1:2] !xtal_osc_en;
    endproperty
    a_halt: assert property (p_halt) else $error("oscillator runs after halt");
    property p_stop;
        stop_exec |-> ##[1:2] !xtal_osc_en;
    endproperty
    a_stop: assert property (p_stop) else $error("oscillator runs in stop");
    property p_hold;
        $rose(cpu_hold) |-> $past(stop_release) && $past(cpu_on_xtal);
    endproperty
    a_hold: assert property (p_hold) else $error("hold without stop exit");
    // A halted oscillator never finishes its count, so the hold must drop.
    property p_hold_clr;
        s_halt_wr |-> ##[1:3] !cpu_hold;
    endproperty
    a_hold_clr: assert property (p_hold_clr) else $error("hold kept after halt");
    property p_mode;
        !(xtal_osc_en && ext_clk_en);
    endproperty
    a_mode: assert property (p_mode) else $error("two pin modes at once");
    property p_port;
        pins_as_port |-> !xtal_osc_en && !ext_clk_en;
    endproperty
    a_port: assert property (p_port) else $error("clock active in port mode");
    property p_sel;
        rd_acc && idx == `XOSC_IDX_SELECT |-> prdata[31:3] == 29'h0;
    endproperty
    a_sel: assert property (p_sel) else $error("select upper bits set");
    property p_stat;
        rd_acc && idx == `XOSC_IDX_STATUS |-> prdata[31:8] == 24'h0 &&
            ((~prdata[7:0]) & ((~prdata[7:0]) + 8'h01)) == 8'h00;
    endproperty
    a_stat: assert property (p_stat) else $error("status not thermometer");
endmodule // xosc_chk
bind xosc_stab xosc_chk #(.ADDR_W(ADDR_W)) xosc_chk_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .stop_exec(stop_exec), .stop_release(stop_release),
    .cpu_on_xtal(cpu_on_xtal), .xtal_osc_en(xtal_osc_en), .ext_clk_en(ext_clk_en),
    .pins_as_port(pins_as_port), .cpu_hold(cpu_hold));
`default_nettype wire

// [test/xosc_stab_bench.sv]
// Self-checking bench of the stabilization counter block.
// Assumes the rtl files and the bound checker; the crystal pin toggles every 2 pclk.
`timescale 1ns/10ps
`default_nettype none
`include "xosc_map.vh"
module xosc_stab_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, xrun = 0, err;
    logic [21:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdata, seed = 32'hf97b;
    logic [3:0] pstrb = 0;
    logic pready, pslverr, xtal_clk_in = 0, stop_exec = 0, stop_release = 0;
    logic cpu_on_xtal = 0, xtal_osc_en, ext_clk_en, pins_as_port, cpu_hold, irq;
    logic [1:0] div = 0;
    logic [2:0] code;
    int errors = 0, comparisons = 0, cycles = 0, i;
    xosc_stab xosc_stab_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .xtal_clk_in(xtal_clk_in), .stop_exec(stop_exec),
        .stop_release(stop_release), .cpu_on_xtal(cpu_on_xtal), .xtal_osc_en(xtal_osc_en),
        .ext_clk_en(ext_clk_en), .pins_as_port(pins_as_port), .cpu_hold(cpu_hold), .irq(irq));
    ////////////////////////////////////////
    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (xrun) begin
            div <= div + 2'h1;
            xtal_clk_in <= div[0] ? ~xtal_clk_in : xtal_clk_in;
        end
        if (cycles == 40000) begin
            errors = errors + 1;
            conclude();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int wexp(input logic [2:0] c);
        return c == 3'h7 ? 18 : (c < 3'h4 ? 8 + c : 5 + 2 * c);
    endfunction
    function automatic logic [31:0] therm(input logic [2:0] c);
        return {24'h0, 8'hff << (3'h7 - c)};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        comparisons = comparisons + 1;
        if (seen !== want) begin
            errors = errors + 1;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // Only the bench timeout ends a wait for pready.
    task automatic apb(input logic wr, input logic [19:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [19:0] idx, input logic [31:0] want);
        apb(1'b0, idx, 32'h0);
        chk(rdata, want);
    endtask
    // Waits past the selected count by whole crystal periods of 4 pclk.
    task automatic settle(input logic [2:0] c);
        repeat ((4 << wexp(c)) + 64) @(posedge pclk);
    endtask
    task automatic conclude();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk({pins_as_port, xtal_osc_en, cpu_hold, irq}, 32'h8);
        rd(`XOSC_IDX_STATUS, 32'h0);
        rd(`XOSC_IDX_SELECT, 32'h7);
        apb(1'b1, `XOSC_IDX_SELECT, 32'hfd);
        rd(`XOSC_IDX_SELECT, 32'h5);
        apb(1'b1, `XOSC_IDX_STATUS, 32'hff);
        rd(`XOSC_IDX_STATUS, 32'h0);
        rd(20'h00123, 32'h0);
        chk({31'h0, err}, 32'h1);
        // Codes stay at 2^10 or less so the run stays short and above 20 us.
        seed = lfsr(seed);
        code = 3'(seed % 3);
        apb(1'b1, `XOSC_IDX_SELECT, {29'h0, code});
        apb(1'b1, `XOSC_IDX_MODE, 32'h40);
        xrun <= 1'b1;
        apb(1'b1, `XOSC_IDX_RUN, 32'h0);
        settle(code);
        settle(code);
        rd(`XOSC_IDX_STATUS, therm(code));
        chk({31'h0, irq}, 32'h0);
        rd(`XOSC_IDX_IRQ_ST, 32'h3);
        apb(1'b1, `XOSC_IDX_IRQ_EN, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `XOSC_IDX_IRQ_CLR, 32'h3);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        stop_exec <= 1'b1;
        @(posedge pclk);
        stop_exec <= 1'b0;
        rd(`XOSC_IDX_STATUS, 32'h0);
        cpu_on_xtal <= 1'b1;
        stop_release <= 1'b1;
        @(posedge pclk);
        stop_release <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({31'h0, cpu_hold}, 32'h1);
        settle(code);
        chk({31'h0, cpu_hold}, 32'h0);
        rd(`XOSC_IDX_STATUS, therm(code));
        apb(1'b1, `XOSC_IDX_RUN, 32'h80);
        rd(`XOSC_IDX_STATUS, 32'h0);
        chk({31'h0, xtal_osc_en}, 32'h0);
        // A crystal that has not begun to swing adds nothing to the count.
        xrun <= 1'b0;
        apb(1'b1, `XOSC_IDX_RUN, 32'h0);
        settle(code);
        rd(`XOSC_IDX_STATUS, 32'h0);
        // STOP exit on the internal clock: no hold, software polls instead.
        xrun <= 1'b1;
        stop_exec <= 1'b1;
        cpu_on_xtal <= 1'b0;
        @(posedge pclk);
        stop_exec <= 1'b0;
        stop_release <= 1'b1;
        @(posedge pclk);
        stop_release <= 1'b0;
        rd(`XOSC_IDX_STATUS, 32'h0);
        chk({31'h0, cpu_hold}, 32'h0);
        settle(code);
        rd(`XOSC_IDX_STATUS, therm(code));
        // Halting the crystal during a held wait must let the CPU go.
        stop_exec <= 1'b1;
        cpu_on_xtal <= 1'b1;
        @(posedge pclk);
        stop_exec <= 1'b0;
        stop_release <= 1'b1;
        @(posedge pclk);
        stop_release <= 1'b0;
        @(posedge pclk);
        chk({31'h0, cpu_hold}, 32'h1);
        apb(1'b1, `XOSC_IDX_RUN, 32'h80);
        repeat (2) @(posedge pclk);
        chk({30'h0, cpu_hold, xtal_osc_en}, 32'h0);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, `XOSC_IDX_MODE, i << 6);
            apb(1'b1, `XOSC_IDX_RUN, 32'h0);
            repeat (2) @(posedge pclk);
            chk({pins_as_port, ext_clk_en, xtal_osc_en}, {!i[0], i[1] & i[0], !i[1] & i[0]});
        end
        conclude();
    end
endmodule // xosc_stab_bench
`default_nettype wire
